/* testbench.sv */
`include "ubrg_map.svh"
`define CHECK(name, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            err_total++; \
            $display("ERROR %s expected %h seen %h", name, exp, got); \
        end \
    end
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import ubrg_pkg::*;
    typedef struct {string name; ubrg_byte_t exp;} ubrg_tb_note_t;
    logic clk = 1'b0;
    logic rst = 1'b1;
    ubrg_sel_t sfr_sel = 2'h0;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    ubrg_byte_t sfr_wdata = 8'h00;
    ubrg_byte_t sfr_rdata_q;
    logic serial_mode_high = 1'b0;
    logic serial_mode_low = 1'b1;
    logic cap_pin = 1'b0;
    logic baud_clk16_q, double_q, detect_dis_q, cap_sel_q, det_cap_q, t2_cap_q;
    ubrg_range_t range_q;
    logic [15:0] pulse_gap_q, bit_time_q, pulse_count_q, snap;
    logic rd_taken = 1'b0;
    int err_total = 0;
    int check_count = 0;
    ubrg_tb_note_t notes[$];
    ubrg_tb_note_t n;
    ubrg_byte_t r;
    ubrg_byte_t v;
    logic [15:0] gap;
    ubrg_top dut (.clk(clk), .rst(rst), .sfr_sel(sfr_sel), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata), .sfr_rdata_q(sfr_rdata_q), .serial_mode_high(serial_mode_high),
        .serial_mode_low(serial_mode_low), .external_capture_pin(cap_pin),
        .baud_clk16_q(baud_clk16_q), .double_rate_select_q(double_q),
        .rate_detect_disable_q(detect_dis_q), .capture_pin_select_q(cap_sel_q),
        .detect_range_select_q(range_q), .detect_capture_q(det_cap_q),
        .timer2_capture_q(t2_cap_q));
    ubrg_serial_model partner (.clk(clk), .rst(rst), .baud_clk16(baud_clk16_q),
        .pulse_gap_q(pulse_gap_q), .bit_time_q(bit_time_q), .pulse_count_q(pulse_count_q));
    always #25 clk = ~clk;
    task automatic final_report();
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic reg_write(input ubrg_sel_t sel, input ubrg_byte_t data);
        @(negedge clk);
        sfr_sel = sel;
        sfr_wdata = data;
        sfr_wr = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask
    task automatic reg_read(input string name, input ubrg_sel_t sel, input ubrg_byte_t exp);
        @(negedge clk);
        sfr_sel = sel;
        sfr_rd = 1'b1;
        notes.push_back('{name, exp});
        @(negedge clk);
        sfr_rd = 1'b0;
    endtask
    task automatic wait_pulses(input int cnt);
        int i;
        snap = pulse_count_q;
        for (i = 0; i < 6000 && pulse_count_q < snap + 16'(cnt); i++) begin
            @(negedge clk);
        end
        if (i == 6000) begin
            $display("ERROR wait_pulses expected %0d pulses seen timeout", cnt);
            err_total++;
            final_report();
        end
    endtask
    task automatic no_pulses(input string name);
        repeat (10) @(negedge clk);
        snap = pulse_count_q;
        repeat (300) @(negedge clk);
        `CHECK(name, snap, pulse_count_q)
    endtask
    always @(posedge clk) rd_taken <= sfr_rd;
    // Oldest note is matched against each read answer
    always @(negedge clk) begin
        if (rd_taken === 1'b1) begin
            if (notes.size() == 0) begin
                $display("ERROR read_note expected note seen none");
                err_total++;
            end else begin
                n = notes.pop_front();
                `CHECK(n.name, n.exp, sfr_rdata_q)
            end
        end
    end
    initial begin
        void'($urandom(13040));
        repeat (12) @(negedge clk);
        rst = 1'b0;
        reg_read("power", `UBRG_SEL_POWER_CONTROL, 8'h00);
        reg_read("control", `UBRG_SEL_BAUD_CONTROL, 8'h00);
        reg_read("timer", `UBRG_SEL_BAUD_TIMER, 8'h00);
        reg_write(`UBRG_SEL_BAUD_CONTROL, 8'h0a);
        reg_write(`UBRG_SEL_BAUD_TIMER, 8'h10);
        reg_read("deferred", `UBRG_SEL_BAUD_TIMER, 8'h00);
        reg_write(`UBRG_SEL_BAUD_CONTROL, 8'h0b);
        reg_read("loaded", `UBRG_SEL_BAUD_TIMER, 8'h10);
        repeat (74) @(negedge clk);
        reg_read("live", `UBRG_SEL_BAUD_TIMER, 8'h0e);
        reg_write(2'h3, 8'hff);
        reg_read("unmapped", 2'h3, 8'h00);
        reg_read("control", `UBRG_SEL_BAUD_CONTROL, 8'h0b);
        reg_write(`UBRG_SEL_POWER_CONTROL, 8'hff);
        reg_read("power", `UBRG_SEL_POWER_CONTROL, 8'h80);
        `CHECK("double", 1'b1, double_q)
        for (int c = 0; c < 8; c++) begin
            r = 8'($urandom_range(3));
            @(negedge clk);
            {serial_mode_high, serial_mode_low} = c[0] ? 2'h3 : 2'h1;
            reg_write(`UBRG_SEL_BAUD_CONTROL, 8'h00);
            reg_write(`UBRG_SEL_BAUD_TIMER, r);
            reg_write(`UBRG_SEL_BAUD_CONTROL, {4'h0, 3'(c), 1'b1});
            gap = 16'((1 << ((c > 5) ? 5 : c)) * (int'(r) + 1));
            wait_pulses(34);
            `CHECK("pulse_gap", gap, pulse_gap_q)
            `CHECK("bit_time", 16'(16 * gap), bit_time_q)
        end
        reg_write(`UBRG_SEL_BAUD_CONTROL, 8'h00);
        no_pulses("stopped");
        @(negedge clk);
        {serial_mode_high, serial_mode_low} = 2'h2;
        for (int d = 0; d < 2; d++) begin
            reg_write(`UBRG_SEL_POWER_CONTROL, d[0] ? 8'h80 : 8'h00);
            wait_pulses(34);
            `CHECK("mode2_gap", d[0] ? 16'h2 : 16'h4, pulse_gap_q)
            `CHECK("mode2_bit", d[0] ? 16'h20 : 16'h40, bit_time_q)
        end
        @(negedge clk);
        {serial_mode_high, serial_mode_low} = 2'h0;
        reg_write(`UBRG_SEL_BAUD_CONTROL, 8'h01);
        no_pulses("reserved_mode");
        for (int i = 0; i < 4; i++) begin
            v = {2'(i), i[0], ~i[0], 4'h0};
            reg_write(`UBRG_SEL_BAUD_CONTROL, v);
            reg_read("control", `UBRG_SEL_BAUD_CONTROL, v);
            `CHECK("detect_disable", ~i[0], detect_dis_q)
            `CHECK("capture_select", i[0], cap_sel_q)
            `CHECK("range", 2'(i), range_q)
            repeat (6) begin
                @(negedge clk);
                `CHECK("detect_pin", i[0] ? 1'b1 : cap_pin, det_cap_q)
                `CHECK("timer2_pin", i[0] ? cap_pin : 1'b1, t2_cap_q)
                cap_pin = 1'($urandom_range(1));
            end
        end
        repeat (4) @(negedge clk);
        final_report();
    end
endmodule // testbench

/* ubrg_map.svh */
`ifndef UBRG_MAP_SVH
`define UBRG_MAP_SVH

// Register select codes on the special function register port
`define UBRG_SEL_POWER_CONTROL 2'h0
`define UBRG_SEL_BAUD_CONTROL 2'h1
`define UBRG_SEL_BAUD_TIMER 2'h2

// Power control register fields
`define UBRG_POWER_CONTROL_REG_DOUBLE_BIT 7

// Baud control register fields
`define UBRG_BAUD_CONTROL_REG_RUN_BIT 0
`define UBRG_BAUD_CONTROL_REG_PRESCALE_HI 3
`define UBRG_BAUD_CONTROL_REG_PRESCALE_LO 1
`define UBRG_BAUD_CONTROL_REG_DETECT_DIS_BIT 4
`define UBRG_BAUD_CONTROL_REG_CAPTURE_SEL_BIT 5
`define UBRG_BAUD_CONTROL_REG_RANGE_HI 7
`define UBRG_BAUD_CONTROL_REG_RANGE_LO 6

// Reset values
`define UBRG_POWER_CONTROL_REG_RESET 8'h00
`define UBRG_BAUD_CONTROL_REG_RESET 8'h00
`define UBRG_RELOAD_RESET 8'h00
`define UBRG_COUNT_RESET 8'h00

// Prescaler
`define UBRG_PRESCALE_MAX_CODE 3'h5
`define UBRG_PRESCALE_WIDTH 5

// Baud clock is sixteen times the bit rate
`define UBRG_OVERSAMPLE 16
// Mode 2 fixed divider, in clock cycles per baud clock pulse
`define UBRG_FIXED_DIV_NORMAL (64 / `UBRG_OVERSAMPLE)
`define UBRG_FIXED_DIV_DOUBLE (32 / `UBRG_OVERSAMPLE)

`endif

/* ubrg_pkg.sv */
package ubrg_pkg;
    typedef logic [7:0] ubrg_byte_t;
    typedef logic [1:0] ubrg_sel_t;
    typedef logic [2:0] ubrg_prescale_t;
    typedef logic [1:0] ubrg_range_t;
    typedef enum logic [1:0] {
        UBRG_MODE_RESERVED,
        UBRG_MODE_VAR_8BIT,
        UBRG_MODE_FIXED_9BIT,
        UBRG_MODE_VAR_9BIT
    } ubrg_mode_t;
endpackage

/* ubrg_prescaler.sv */
`include "ubrg_map.svh"

module ubrg_prescaler (
    input wire logic clk, // Peripheral clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic run, // Generator running
    input wire ubrg_pkg::ubrg_prescale_t code, // Prescale select
    output logic tick // One pulse per prescaled clock period
);
    import ubrg_pkg::*;

    logic [`UBRG_PRESCALE_WIDTH-1:0] cnt_q;
    logic [`UBRG_PRESCALE_WIDTH-1:0] mask;
    ubrg_prescale_t eff_code;

    // Reserved codes behave as the slowest division
    always_comb begin
        eff_code = (code > `UBRG_PRESCALE_MAX_CODE) ? `UBRG_PRESCALE_MAX_CODE : code;
        mask = `UBRG_PRESCALE_WIDTH'((1 << eff_code) - 1);
        tick = run && ((cnt_q & mask) == mask);
    end

    // Free count held at zero while stopped, so each start is aligned
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_q <= '0;
        end else if (!run) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_q + `UBRG_PRESCALE_WIDTH'(1);
        end
    end
endmodule // ubrg_prescaler

/* ubrg_serial_model.sv */
module ubrg_serial_model (
    input wire logic clk, // Peripheral clock
    input wire logic rst, // Asynchronous reset, active high
    input wire logic baud_clk16, // Baud clock pulses from the generator
    output logic [15:0] pulse_gap_q, // Cycles between the last two pulses
    output logic [15:0] bit_time_q, // Cycles per serial bit
    output logic [15:0] pulse_count_q // Pulses seen since reset
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] gap_q;
    logic [15:0] bit_cnt_q;
    logic [3:0] div_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            gap_q <= 16'h0;
            bit_cnt_q <= 16'h0;
            div_q <= 4'h0;
            pulse_gap_q <= 16'h0;
            bit_time_q <= 16'h0;
            pulse_count_q <= 16'h0;
        end else begin
            gap_q <= gap_q + 16'h1;
            bit_cnt_q <= bit_cnt_q + 16'h1;
            if (baud_clk16) begin
                pulse_gap_q <= gap_q + 16'h1;
                gap_q <= 16'h0;
                pulse_count_q <= pulse_count_q + 16'h1;
                div_q <= div_q + 4'h1;
                // One serial bit per sixteen baud clock pulses
                if (div_q == 4'hf) begin
                    bit_time_q <= bit_cnt_q + 16'h1;
                    bit_cnt_q <= 16'h0;
                end
            end
        end
    end
endmodule // ubrg_serial_model

/* ubrg_top.sv */
`include "ubrg_map.svh"

// How it works
// - Output baud clock runs sixteen times bit rate
// - Mode 2 divides clock by 64 or 32
// - Modes 1 and 3 use generator underflows
// - Bit 7 of power control doubles mode 2
// - Three-bit prescaler feeds eight-bit reload timer
// - Timer counts while running; underflow gives pulse
// - Underflow reloads timer from reload register
// - Reads return live count; writes set reload
// - Write loads timer, deferred until run set
// - Rate is clock/(16*prescale*(reload+1))
// - Prescale codes 000..101 divide 1 to 32
// - Control bit 0 starts and stops generator
// - Control bit 4 disables rate detection
// - Control bit 5 routes capture pin
// - Control bits 7:6 pick detection range
// - Serial mode picks fixed or variable source
module ubrg_top (
    input wire logic clk, // Peripheral clock, 20 MHz
    input wire logic rst, // Asynchronous reset, active high
    input wire ubrg_pkg::ubrg_sel_t sfr_sel, // Register select
    input wire logic sfr_wr, // Write strobe, one cycle
    input wire logic sfr_rd, // Read strobe, one cycle
    input wire ubrg_pkg::ubrg_byte_t sfr_wdata, // Write data
    output ubrg_pkg::ubrg_byte_t sfr_rdata_q, // Read data, valid after a read strobe
    input wire logic serial_mode_high, // Serial mode bit, upper
    input wire logic serial_mode_low, // Serial mode bit, lower
    input wire logic external_capture_pin, // Capture pin level
    output logic baud_clk16_q, // Baud clock pulse to the serial channel
    output logic double_rate_select_q, // Mode 2 double rate
    output logic rate_detect_disable_q, // Rate detection disabled
    output logic capture_pin_select_q, // Capture pin routed to timer function
    output ubrg_pkg::ubrg_range_t detect_range_select_q, // Detection rate range
    output logic detect_capture_q, // Capture pin as seen by rate detection
    output logic timer2_capture_q // Capture pin as seen by the timer function
);
    import ubrg_pkg::*;

    // Control state
    logic run_q;
    ubrg_prescale_t prescale_select_q;
    ubrg_byte_t reload_value_q;
    ubrg_byte_t count_q;
    logic load_pending_q;
    logic run_prev_q;
    logic [1:0] fixed_cnt_q;

    // Decoded strobes
    logic power_control_reg_wr;
    logic baud_control_reg_wr;
    logic bg_wr;
    logic bg_rd;
    ubrg_mode_t mode;
    logic var_mode;
    logic fixed_mode;
    logic div_tick;
    logic underflow;
    logic run_start;
    logic fixed_pulse;
    logic [1:0] fixed_top;

    always_comb begin
        power_control_reg_wr = sfr_wr && (sfr_sel == `UBRG_SEL_POWER_CONTROL);
        baud_control_reg_wr = sfr_wr && (sfr_sel == `UBRG_SEL_BAUD_CONTROL);
        bg_wr = sfr_wr && (sfr_sel == `UBRG_SEL_BAUD_TIMER);
        bg_rd = sfr_rd && (sfr_sel == `UBRG_SEL_BAUD_TIMER);
    end

    // Serial mode selects the baud clock source
    always_comb begin
        mode = ubrg_mode_t'({serial_mode_high, serial_mode_low});
        var_mode = (mode == UBRG_MODE_VAR_8BIT) || (mode == UBRG_MODE_VAR_9BIT);
        fixed_mode = (mode == UBRG_MODE_FIXED_9BIT);
    end

    ubrg_prescaler u_prescaler (
        .clk(clk),
        .rst(rst),
        .run(run_q),
        .code(prescale_select_q),
        .tick(div_tick)
    );

    always_comb begin
        run_start = run_q && !run_prev_q;
        underflow = div_tick && (count_q == 8'h00);
    end

    // Power control: only the double rate bit is held here
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            double_rate_select_q <= 1'(`UBRG_POWER_CONTROL_REG_RESET >> `UBRG_POWER_CONTROL_REG_DOUBLE_BIT);
        end else if (power_control_reg_wr) begin
            double_rate_select_q <= sfr_wdata[`UBRG_POWER_CONTROL_REG_DOUBLE_BIT];
        end
    end

    // Baud control register
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_q <= 1'b0;
            prescale_select_q <= 3'h0;
            rate_detect_disable_q <= 1'b0;
            capture_pin_select_q <= 1'b0;
            detect_range_select_q <= 2'h0;
        end else if (baud_control_reg_wr) begin
            run_q <= sfr_wdata[`UBRG_BAUD_CONTROL_REG_RUN_BIT];
            prescale_select_q <= sfr_wdata[`UBRG_BAUD_CONTROL_REG_PRESCALE_HI:`UBRG_BAUD_CONTROL_REG_PRESCALE_LO];
            rate_detect_disable_q <= sfr_wdata[`UBRG_BAUD_CONTROL_REG_DETECT_DIS_BIT];
            capture_pin_select_q <= sfr_wdata[`UBRG_BAUD_CONTROL_REG_CAPTURE_SEL_BIT];
            detect_range_select_q <= sfr_wdata[`UBRG_BAUD_CONTROL_REG_RANGE_HI:`UBRG_BAUD_CONTROL_REG_RANGE_LO];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            run_prev_q <= 1'b0;
        end else begin
            run_prev_q <= run_q;
        end
    end

    // Reload register: every write lands here, running or not
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reload_value_q <= `UBRG_RELOAD_RESET;
        end else if (bg_wr) begin
            reload_value_q <= sfr_wdata;
        end
    end

    // A write while stopped is remembered and applied once run is set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            load_pending_q <= 1'b0;
        end else if (bg_wr && !run_q) begin
            load_pending_q <= 1'b1;
        end else if (run_start) begin
            load_pending_q <= 1'b0;
        end
    end

    // Down counter with auto reload
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            count_q <= `UBRG_COUNT_RESET;
        end else if (bg_wr && run_q) begin
            count_q <= sfr_wdata;
        end else if (run_start && load_pending_q) begin
            count_q <= reload_value_q;
        end else if (underflow) begin
            count_q <= reload_value_q;
        end else if (div_tick) begin
            count_q <= count_q - 8'h01;
        end
    end

    // Mode 2 fixed divider for the sixteen-times clock
    always_comb begin
        fixed_top = double_rate_select_q ? 2'(`UBRG_FIXED_DIV_DOUBLE - 1)
                                         : 2'(`UBRG_FIXED_DIV_NORMAL - 1);
        fixed_pulse = fixed_mode && (fixed_cnt_q >= fixed_top);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            fixed_cnt_q <= 2'h0;
        end else if (!fixed_mode || fixed_pulse) begin
            fixed_cnt_q <= 2'h0;
        end else begin
            fixed_cnt_q <= fixed_cnt_q + 2'h1;
        end
    end

    // Baud clock: one pulse per underflow or per fixed period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            baud_clk16_q <= 1'b0;
        end else if (var_mode) begin
            baud_clk16_q <= underflow;
        end else begin
            baud_clk16_q <= fixed_pulse;
        end
    end

    // Register read port; timer select returns the live count
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sfr_rdata_q <= 8'h00;
        end else if (sfr_rd) begin
            case (sfr_sel)
                `UBRG_SEL_POWER_CONTROL: begin
                    sfr_rdata_q <= {double_rate_select_q, 7'h00};
                end
                `UBRG_SEL_BAUD_CONTROL: begin
                    sfr_rdata_q <= {detect_range_select_q, capture_pin_select_q,
                                    rate_detect_disable_q, prescale_select_q, run_q};
                end
                `UBRG_SEL_BAUD_TIMER: begin
                    sfr_rdata_q <= count_q;
                end
                default: begin
                    sfr_rdata_q <= 8'h00;
                end
            endcase
        end
    end

    // Capture pin routing
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            detect_capture_q <= 1'b1;
            timer2_capture_q <= 1'b1;
        end else begin
            detect_capture_q <= capture_pin_select_q ? 1'b1 : external_capture_pin;
            timer2_capture_q <= capture_pin_select_q ? external_capture_pin : 1'b1;
        end
    end

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    underflow_pulse_a: assert property (var_mode && underflow |=> baud_clk16_q)
        else $error("underflow gave no baud pulse");

    no_spurious_pulse_a: assert property (var_mode && !underflow |=> !baud_clk16_q)
        else $error("baud pulse without underflow");

    reload_on_under_a: assert property (
        underflow && !bg_wr && !(run_start && load_pending_q)
        |=> count_q == $past(reload_value_q))
        else $error("timer not reloaded on underflow");

    count_down_a: assert property (
        div_tick && count_q != 8'h00 && !bg_wr && !(run_start && load_pending_q)
        |=> count_q == $past(count_q) - 8'h01)
        else $error("timer did not count down");

    stopped_hold_a: assert property (!run_q && !bg_wr && !run_start |=> $stable(count_q))
        else $error("timer moved while stopped");

    timer_read_a: assert property (bg_rd |=> sfr_rdata_q == $past(count_q))
        else $error("timer read did not return count");

    reload_write_a: assert property (bg_wr |=> reload_value_q == $past(sfr_wdata))
        else $error("write did not reach reload register");

    deferred_load_a: assert property (
        run_start && load_pending_q && !bg_wr |=> count_q == $past(reload_value_q))
        else $error("deferred load missed after run set");

    prescale_one_a: assert property (
        run_q && prescale_select_q == 3'h0 && !baud_control_reg_wr |-> div_tick)
        else $error("prescale one did not tick every cycle");

    prescale_two_a: assert property (
        div_tick && prescale_select_q == 3'h1 && !baud_control_reg_wr ##1 !baud_control_reg_wr |-> !div_tick)
        else $error("prescale two ticked twice in a row");

    fixed_slow_a: assert property (
        fixed_mode && !double_rate_select_q && baud_clk16_q
        ##1 (fixed_mode && !double_rate_select_q)[*3]
        |=> baud_clk16_q && !$past(baud_clk16_q) && !$past(baud_clk16_q, 2)
        && !$past(baud_clk16_q, 3))
        else $error("mode 2 normal rate wrong");

    fixed_fast_a: assert property (
        fixed_mode && double_rate_select_q && baud_clk16_q
        ##1 (fixed_mode && double_rate_select_q)
        |=> baud_clk16_q && !$past(baud_clk16_q))
        else $error("mode 2 double rate wrong");

    capture_route_a: assert property (
        !capture_pin_select_q |=> detect_capture_q == $past(external_capture_pin))
        else $error("capture pin not routed to detection");

    control_write_a: assert property (
        baud_control_reg_wr |=> run_q == $past(sfr_wdata[0]) && rate_detect_disable_q == $past(sfr_wdata[4])
        && detect_range_select_q == $past(sfr_wdata[7:6]))
        else $error("control write not stored");

    run_gate_a: assert property (var_mode && !run_q |=> !baud_clk16_q)
        else $error("baud pulse while generator stopped");

    idle_mode_a: assert property (!var_mode && !fixed_mode |=> !baud_clk16_q)
        else $error("baud pulse in reserved serial mode");

    running_load_a: assert property (bg_wr && run_q |=> count_q == $past(sfr_wdata))
        else $error("running write did not load timer");

    pending_set_a: assert property (
        bg_wr && !run_q |=> load_pending_q && $stable(count_q))
        else $error("stopped write not deferred");

    pending_clear_a: assert property (run_start |=> !load_pending_q)
        else $error("deferred load left pending");

    power_write_a: assert property (
        power_control_reg_wr |=> double_rate_select_q == $past(sfr_wdata[7]))
        else $error("double rate bit not stored");

    power_read_a: assert property (
        sfr_rd && sfr_sel == `UBRG_SEL_POWER_CONTROL
        |=> sfr_rdata_q == {$past(double_rate_select_q), 7'h00})
        else $error("power control read wrong");

    prescale_write_a: assert property (
        baud_control_reg_wr |=> prescale_select_q == $past(sfr_wdata[3:1])
        && capture_pin_select_q == $past(sfr_wdata[5]))
        else $error("prescale or capture select not stored");

    control_read_a: assert property (
        sfr_rd && sfr_sel == `UBRG_SEL_BAUD_CONTROL
        |=> sfr_rdata_q[0] == $past(run_q)
        && sfr_rdata_q[3:1] == $past(prescale_select_q))
        else $error("control read wrong");

    detect_read_a: assert property (
        sfr_rd && sfr_sel == `UBRG_SEL_BAUD_CONTROL
        |=> sfr_rdata_q[7:4] == {$past(detect_range_select_q),
        $past(capture_pin_select_q), $past(rate_detect_disable_q)})
        else $error("detection fields read wrong");

    unmapped_read_a: assert property (
        sfr_rd && sfr_sel == 2'h3 |=> sfr_rdata_q == 8'h00)
        else $error("unmapped read not zero");

    timer_route_a: assert property (
        capture_pin_select_q |=> timer2_capture_q == $past(external_capture_pin)
        && detect_capture_q)
        else $error("capture pin not routed to timer function");

    reserved_prescale_a: assert property (
        div_tick && prescale_select_q > `UBRG_PRESCALE_MAX_CODE && !baud_control_reg_wr
        |=> !div_tick)
        else $error("reserved prescale code ticked too fast");

    mode_source_a: assert property (
        fixed_mode |=> baud_clk16_q == $past(fixed_pulse))
        else $error("mode 2 pulse not from fixed divider");

    var_underflow_c: cover property (var_mode && underflow ##1 baud_clk16_q);
    deferred_load_c: cover property (bg_wr && !run_q ##[1:20] run_start);
    fixed_double_c: cover property (fixed_mode && double_rate_select_q && baud_clk16_q);
    timer_read_c: cover property (bg_rd && run_q);
    mode3_pulse_c: cover property (serial_mode_high && serial_mode_low && underflow);
endmodule // ubrg_top
